// file: dv/core_seq_model.sv
// Purpose: Core sequencer and handler software stand-in
// Assumes: Strobes change just after a rising edge
// Notes: Keeps only a program counter; nothing else is saved
`default_nettype none
module core_seq_model #(parameter PC_W = 13) (
	input wire logic clk,
	input wire logic pc_load,
	input wire logic [PC_W-1:0] next_pc,
	output logic instr_end,
	output logic ret_instr,
	output logic halt_instr,
	output logic [PC_W-1:0] return_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [PC_W-1:0] pc = '0; // Software view of execution point
	// Return address is the next instruction; only it is pushed
	assign return_pc = pc + {{(PC_W-1){1'b0}}, 1'b1};
	initial {halt_instr, ret_instr, instr_end} = 3'h0;
	// Follow every load the block commands
	always @(posedge clk) begin
		if (pc_load) begin
			pc <= next_pc;
		end
	end
	// One-cycle strobe, then idle edges so any load has landed in pc on return
	task automatic step(input logic [2:0] m);
		{halt_instr, ret_instr, instr_end} <= m;
		@(posedge clk);
		{halt_instr, ret_instr, instr_end} <= 3'h0;
		repeat (2) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: dv/irq_ctl_checker_assertions.sv
// Purpose: Temporal checks on the interrupt block ports
// Assumes: One clock, RESETN async active low
// Notes: Bound to every instance of the block
`default_nettype none
module irq_ctl_checker #(parameter PC_W = 13) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic INSTR_END,
	input wire logic RETURN_FROM_IRQ_INSTR,
	input wire logic IRQ_REQUEST,
	input wire logic VECTOR_TAKE,
	input wire logic [PC_W-1:0] NEXT_PC,
	input wire logic PC_LOAD,
	input wire logic HALTED,
	input wire logic WAKE
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// Checks
	// ----------------
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_take_vector: assert property (IRQ_REQUEST && INSTR_END |=>
		VECTOR_TAKE && PC_LOAD && NEXT_PC == 'h4) else $error("vector not loaded");
	a_take_cause: assert property (VECTOR_TAKE |-> $past(IRQ_REQUEST))
		else $error("take without request");
	a_global_clear: assert property (IRQ_REQUEST && INSTR_END |=> !IRQ_REQUEST)
		else $error("global enable kept on take");
	a_load_cause: assert property (PC_LOAD |->
		$past(IRQ_REQUEST && (INSTR_END || HALTED) || RETURN_FROM_IRQ_INSTR))
		else $error("pc load without cause");
	a_wake_pulse: assert property (WAKE |=> !WAKE) else $error("wake too long");
	a_wake_halt: assert property (WAKE |-> !HALTED && $past(HALTED))
		else $error("wake without halt");
	a_halt_exit: assert property ($fell(HALTED) |-> WAKE) else $error("halt left silently");
	a_wake_vector: assert property (HALTED && IRQ_REQUEST |=> VECTOR_TAKE)
		else $error("wake did not vector");
	// Main scenarios reached
	c_take: cover property (VECTOR_TAKE);
	c_wake: cover property (WAKE);
	c_ret: cover property (RETURN_FROM_IRQ_INSTR ##1 PC_LOAD);
endmodule
bind core_interrupt_control irq_ctl_checker #(.PC_W(PC_W)) u_chk (.CLK(CLK),
	.RESETN(RESETN), .INSTR_END(INSTR_END), .RETURN_FROM_IRQ_INSTR(RETURN_FROM_IRQ_INSTR),
	.IRQ_REQUEST(IRQ_REQUEST), .VECTOR_TAKE(VECTOR_TAKE), .NEXT_PC(NEXT_PC),
	.PC_LOAD(PC_LOAD), .HALTED(HALTED), .WAKE(WAKE));
`default_nettype wire

// file: dv/tb.sv
// Purpose: Directed test of the interrupt block over APB
// Assumes: Zero-wait slave, but waits on PREADY anyway
// Notes: Handler clears flags before re-enabling
`include "irq_ctl_map.vh"
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic ext_pin = 1'b0, t0_wrap = 1'b0, pready, pslverr, err, irq_req, take, pc_load;
	logic halted, wake, ovf, instr_end, ret_i, halt_i;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0] port_hi = 4'h0;
	logic [7:0] set_a = 8'h00, set_b = 8'h00;
	logic [12:0] ret_pc, next_pc;
	int fails = 0, cmp_count = 0;
	always #5 clk = ~clk;
	core_interrupt_control dut (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .EXT_IRQ_PIN(ext_pin),
		.SECOND_IO_PORT_HI(port_hi), .TIMER0_WRAP(t0_wrap), .PERIPH_SET_A(set_a),
		.PERIPH_SET_B(set_b), .INSTR_END(instr_end), .RETURN_PC(ret_pc),
		.RETURN_FROM_IRQ_INSTR(ret_i), .HALT_INSTR(halt_i), .IRQ_REQUEST(irq_req),
		.VECTOR_TAKE(take), .NEXT_PC(next_pc), .PC_LOAD(pc_load), .HALTED(halted),
		.WAKE(wake), .STACK_OVERFLOW(ovf));
	core_seq_model core (.clk(clk), .pc_load(pc_load), .next_pc(next_pc),
		.instr_end(instr_end), .ret_instr(ret_i), .halt_instr(halt_i), .return_pc(ret_pc));
	// ----------------
	// Bus tasks
	// ----------------
	// Setup, access held until PREADY, then one idle edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
		logic ok;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// Sample the settled answer mid-cycle; it is taken at the next rising edge
		do begin
			@(negedge clk);
			ok = pready;
			rdat = prdata;
			err = pslverr;
			@(posedge clk);
		end while (ok !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(a, 1'b0, 8'h00);
		`CHK("rdata", e, rdat[7:0])
	endtask
	// Pin change, then room for sync, flag and any take
	task automatic pin(input logic v);
		ext_pin <= v;
		repeat (6) @(posedge clk);
	endtask
	task automatic end_sim;
		if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		end_sim;
	end
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(`OFF_CONTROL, 8'h00);
		rd(`OFF_OPTION, 8'hFF);
		{t0_wrap, set_a, set_b} <= {1'b1, 8'h81, 8'h02};
		@(posedge clk);
		{t0_wrap, set_a, set_b} <= 17'h0;
		@(posedge clk);
		rd(`OFF_CONTROL, 8'h04);
		rd(`OFF_PFLAG_A, 8'h81);
		rd(`OFF_PFLAG_B, 8'h02);
		apb(`OFF_CONTROL, 1'b1, 8'h24);
		`CHK("irq_request", 1'b0, irq_req)
		apb(`OFF_CONTROL, 1'b1, 8'hA4);
		`CHK("irq_request", 1'b1, irq_req)
		core.step(3'b001);
		`CHK("pc", 13'h0004, core.pc)
		rd(`OFF_CONTROL, 8'h24);
		apb(`OFF_CONTROL, 1'b1, 8'h20);
		core.step(3'b010);
		`CHK("pc", 13'h0001, core.pc)
		rd(`OFF_CONTROL, 8'hA0);
		apb(`OFF_CONTROL, 1'b1, 8'h80);
		pin(1'b1);
		rd(`OFF_CONTROL, 8'h82);
		`CHK("irq_request", 1'b0, irq_req)
		apb(`OFF_OPTION, 1'b1, 8'hBF);
		apb(`OFF_CONTROL, 1'b1, 8'h10);
		core.step(3'b100);
		`CHK("halted", 1'b1, halted)
		pin(1'b0);
		`CHK("halted", 1'b0, halted)
		`CHK("pc", 13'h0001, core.pc)
		rd(`OFF_CONTROL, 8'h12);
		apb(`OFF_CONTROL, 1'b1, 8'h90);
		pin(1'b1);
		rd(`OFF_CONTROL, 8'h90);
		core.step(3'b100);
		pin(1'b0);
		`CHK("pc", 13'h0004, core.pc)
		apb(`OFF_CONTROL, 1'b1, 8'h08);
		port_hi <= 4'h5;
		repeat (6) @(posedge clk);
		rd(`OFF_CONTROL, 8'h09);
		apb(`OFF_PEN_A, 1'b1, 8'h01);
		apb(`OFF_CONTROL, 1'b1, 8'hC0);
		`CHK("irq_request", 1'b1, irq_req)
		apb(12'h020, 1'b0, 8'h00);
		`CHK("slverr", 1'b1, err)
		rd(`OFF_STATUS, 8'h21);
		rd(`OFF_CORE, 8'h0A);
		end_sim;
	end
endmodule
`default_nettype wire

// file: hw/core_interrupt_control.v
// Purpose: Interrupt flags, enables, vectoring and halt wake-up for the core.
// Assumes: APB slave, zero wait states; core drives the strobes below.
// Notes: Peripheral flags arrive as one-cycle set pulses from same clock.
`include "irq_ctl_map.vh"
`default_nettype none
module core_interrupt_control #(
	parameter PC_W = 13,
	parameter DEPTH = `STACK_DEPTH
) (
	input wire CLK,
	input wire RESETN,
	// APB
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// Pins
	input wire EXT_IRQ_PIN,
	input wire [3:0] SECOND_IO_PORT_HI,
	// Same-clock event sources
	input wire TIMER0_WRAP,
	input wire [7:0] PERIPH_SET_A,
	input wire [7:0] PERIPH_SET_B,
	// Core sequencer
	input wire INSTR_END,
	input wire [PC_W-1:0] RETURN_PC,
	input wire RETURN_FROM_IRQ_INSTR,
	input wire HALT_INSTR,
	output wire IRQ_REQUEST,
	output reg VECTOR_TAKE,
	output reg [PC_W-1:0] NEXT_PC,
	output reg PC_LOAD,
	output reg HALTED,
	output reg WAKE,
	output reg STACK_OVERFLOW
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] irq_control_reg_q; // Global, enables and core flags
	reg [7:0] option_q; // Edge select at bit 6
	reg [7:0] periph_flag_reg_a_q;
	reg [7:0] periph_flag_reg_b_q;
	reg [7:0] periph_enable_reg_a_q;
	reg [7:0] periph_enable_reg_b_q;
	reg [PC_W-1:0] stack_q [0:DEPTH-1]; // Return addresses only
	reg [3:0] sp_q; // Stack depth in use
	reg [3:0] port_last_q; // Port value seen by last compare

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [4:0] pin_q;
	wire [4:0] pin_rise;
	wire [4:0] pin_fall;
	edge_sync #(.W(5)) u_sync (
		.CLK(CLK),
		.RESETN(RESETN),
		.D({SECOND_IO_PORT_HI, EXT_IRQ_PIN}),
		.Q(pin_q),
		.RISE(pin_rise),
		.FALL(pin_fall)
	);
	// Two sync stages plus one flag stage keeps pin latency in 2-3 cycles
	wire ext_edge_select = option_q[`B_EDGE_SEL];
	wire ext_event = ext_edge_select ? pin_rise[0] : pin_fall[0];
	// Any change on the upper four port pins versus last value
	wire port_event = |(pin_q[4:1] ^ port_last_q);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire acc = PSEL & PENABLE;
	wire wr = acc & PWRITE & PSTRB[0];
	wire hit_ctl = (PADDR == `OFF_CONTROL);
	wire hit_opt = (PADDR == `OFF_OPTION);
	wire hit_fa = (PADDR == `OFF_PFLAG_A);
	wire hit_fb = (PADDR == `OFF_PFLAG_B);
	wire hit_ea = (PADDR == `OFF_PEN_A);
	wire hit_eb = (PADDR == `OFF_PEN_B);
	wire hit_st = (PADDR == `OFF_STATUS);
	wire hit_core = (PADDR == `OFF_CORE);
	wire mapped = hit_ctl | hit_opt | hit_fa | hit_fb | hit_ea | hit_eb | hit_st | hit_core;
	assign PREADY = 1'b1; // Zero wait states
	assign PSLVERR = acc & ~mapped; // Unmapped access errors

	// ----------------------------------------
	// Request logic
	// ----------------------------------------
	wire [7:0] c = irq_control_reg_q;
	wire core_pend = (c[`B_T0_FLAG] & c[`B_T0_EN]) | (c[`B_EXT_FLAG] & c[`B_EXT_EN])
		| (c[`B_PORT_FLAG] & c[`B_PORT_EN]);
	wire per_pend = c[`B_PERIPH_EN] & (|(periph_flag_reg_a_q & periph_enable_reg_a_q)
		| |(periph_flag_reg_b_q & periph_enable_reg_b_q));
	wire any_pend = core_pend | per_pend;
	assign IRQ_REQUEST = c[`B_GLOBAL] & any_pend;
	// Take at the next instruction boundary, or at once while halted
	wire take = IRQ_REQUEST & (INSTR_END | HALTED);
	wire do_ret = RETURN_FROM_IRQ_INSTR & (sp_q != 4'h0) & ~take;

	// ----------------------------------------
	// Control register: hardware updates win over software writes
	// ----------------------------------------
	reg [7:0] ctl_d;
	always @* begin
		ctl_d = irq_control_reg_q;
		if (wr & hit_ctl) begin
			ctl_d = PWDATA[7:0];
		end
		if (take) begin
			ctl_d[`B_GLOBAL] = 1'b0;
		end else if (do_ret) begin
			ctl_d[`B_GLOBAL] = 1'b1;
		end
		// Flags stay set until software clears them; software must do so
		if (ext_event) begin
			ctl_d[`B_EXT_FLAG] = 1'b1;
		end
		if (TIMER0_WRAP) begin
			ctl_d[`B_T0_FLAG] = 1'b1;
		end
		if (port_event) begin
			ctl_d[`B_PORT_FLAG] = 1'b1;
		end
	end

	// Register file and flags
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_control_reg_q <= `RST_CONTROL;
			option_q <= `RST_OPTION;
			periph_flag_reg_a_q <= `RST_PERIPH;
			periph_flag_reg_b_q <= `RST_PERIPH;
			periph_enable_reg_a_q <= `RST_PERIPH;
			periph_enable_reg_b_q <= `RST_PERIPH;
			port_last_q <= 4'h0;
		end else begin
			irq_control_reg_q <= ctl_d;
			port_last_q <= pin_q[4:1];
			if (wr & hit_opt) begin
				option_q <= PWDATA[7:0];
			end
			if (wr & hit_ea) begin
				periph_enable_reg_a_q <= PWDATA[7:0];
			end
			if (wr & hit_eb) begin
				periph_enable_reg_b_q <= PWDATA[7:0];
			end
			// Peripheral flags: hardware set beats software write
			periph_flag_reg_a_q <= ((wr & hit_fa) ? PWDATA[7:0] : periph_flag_reg_a_q)
				| PERIPH_SET_A;
			periph_flag_reg_b_q <= ((wr & hit_fb) ? PWDATA[7:0] : periph_flag_reg_b_q)
				| PERIPH_SET_B;
		end
	end

	// ----------------------------------------
	// Return stack and vectoring
	// ----------------------------------------
	// Only the return address is pushed; working state is software's job
	always @(posedge CLK) begin
		if (take & (sp_q < DEPTH)) begin
			stack_q[sp_q[2:0]] <= RETURN_PC;
		end
	end

	// Stack pointer, vector and return outputs
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sp_q <= 4'h0;
			VECTOR_TAKE <= 1'b0;
			PC_LOAD <= 1'b0;
			NEXT_PC <= {PC_W{1'b0}};
			STACK_OVERFLOW <= 1'b0;
		end else begin
			VECTOR_TAKE <= take;
			PC_LOAD <= take | do_ret;
			if (take) begin
				NEXT_PC <= `IRQ_VECTOR;
				if (sp_q < DEPTH) begin
					sp_q <= sp_q + 4'h1;
				end else begin
					// Full stack: address lost, sticky warning kept
					STACK_OVERFLOW <= 1'b1;
				end
			end else if (do_ret) begin
				NEXT_PC <= stack_q[sp_q[2:0] - 3'h1];
				sp_q <= sp_q - 4'h1;
			end
		end
	end

	// ----------------------------------------
	// Halt and wake-up
	// ----------------------------------------
	// Wake on any enabled pending source, global enable ignored
	// Flags stay set so the waking source is visible
	// With global clear, core resumes in line after the halt
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			HALTED <= 1'b0;
			WAKE <= 1'b0;
		end else begin
			WAKE <= 1'b0;
			if (HALTED) begin
				if (any_pend) begin
					HALTED <= 1'b0;
					WAKE <= 1'b1;
				end
			end else if (HALT_INSTR & ~any_pend) begin
				// Pending source makes the halt act as no-op
				HALTED <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		PRDATA = 32'h0000_0000;
		if (acc & ~PWRITE) begin
			if (hit_ctl) PRDATA[7:0] = irq_control_reg_q;
			if (hit_opt) PRDATA[7:0] = option_q;
			if (hit_fa) PRDATA[7:0] = periph_flag_reg_a_q;
			if (hit_fb) PRDATA[7:0] = periph_flag_reg_b_q;
			if (hit_ea) PRDATA[7:0] = periph_enable_reg_a_q;
			if (hit_eb) PRDATA[7:0] = periph_enable_reg_b_q;
			if (hit_st) PRDATA[7:0] = {STACK_OVERFLOW, HALTED, IRQ_REQUEST, 1'b0, sp_q};
			if (hit_core) PRDATA[7:0] = {3'h0, pin_q};
		end
	end
	// Up to 19 sources: 3 core plus 8+8 peripheral slots, 11 used typically
endmodule
`default_nettype wire

// file: hw/edge_sync.v
// Purpose: Two-stage synchroniser with edge report for async pins.
// Assumes: One clock, async active-low reset.
// Notes: First stage feeds only the second stage.
`default_nettype none
module edge_sync #(
	parameter W = 5
) (
	input wire CLK,
	input wire RESETN,
	input wire [W-1:0] D,
	output reg [W-1:0] Q,
	output wire [W-1:0] RISE,
	output wire [W-1:0] FALL
);
	// ----------------------------------------
	// Stages
	// ----------------------------------------
	reg [W-1:0] meta_q; // First stage, read only by Q
	reg [W-1:0] last_q; // Previous settled value
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			// Per-bit sync and history
			always @(posedge CLK or negedge RESETN) begin
				if (!RESETN) begin
					meta_q[i] <= 1'b0;
					Q[i] <= 1'b0;
					last_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= D[i];
					Q[i] <= meta_q[i];
					last_q[i] <= Q[i];
				end
			end
			assign RISE[i] = Q[i] & ~last_q[i];
			assign FALL[i] = ~Q[i] & last_q[i];
		end
	endgenerate
endmodule
`default_nettype wire

// file: hw/irq_ctl_map.vh
// Purpose: Constants for the core interrupt control block.
// Assumes: APB, 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses.
`ifndef IRQ_CTL_MAP_VH
`define IRQ_CTL_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CONTROL 12'h000
`define OFF_OPTION 12'h004
`define OFF_PFLAG_A 12'h008
`define OFF_PFLAG_B 12'h00C
`define OFF_PEN_A 12'h010
`define OFF_PEN_B 12'h014
`define OFF_STATUS 12'h018
`define OFF_CORE 12'h01C

// ----------------------------------------
// Control and option register fields
// ----------------------------------------
`define B_GLOBAL 7
`define B_PERIPH_EN 6
`define B_T0_EN 5
`define B_EXT_EN 4
`define B_PORT_EN 3
`define B_T0_FLAG 2
`define B_EXT_FLAG 1
`define B_PORT_FLAG 0
`define B_EDGE_SEL 6

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define RST_CONTROL 8'h00
`define RST_OPTION 8'hFF
`define RST_PERIPH 8'h00
`define IRQ_VECTOR 13'h0004
`define STACK_DEPTH 8
`define LAT_SYNC 2
`endif
